// ### hw/spi_cmd_port.v
// Purpose: Four-wire serial slave command port: 24-bit frames, write/read.
// Assumes: Serial pins are sampled by a 200 MHz clock through two flops.
// Notes: Serial clock up to 20 MHz; writes leave through a two-entry buffer.
`timescale 1ns/1ps
`include "spi_cmd_defines.vh"
module spi_cmd_port (
    input wire clock, // 200 MHz block clock
    input wire rst_b, // Async reset, active low
    input wire spi_mode_sel, // Strap: high four-wire, low leaves the port idle (no two-wire logic)
    input wire serial_clk, // Serial clock pin from master
    input wire serial_din, // Serial data in pin
    input wire addr0_or_chip_select, // Chip select pin, active low
    input wire addr2_or_unused, // Unused in four-wire mode
    output wire addr1_or_serial_out, // Serial output data
    output wire addr1_or_serial_out_oe, // Serial output drive enable
    output reg [6:0] rd_addr, // Read register address
    output reg rd_req, // Read address valid pulse
    input wire [15:0] rd_data, // Read data, sampled in the same cycle as rd_req
    output wire wr_valid, // Write word available
    input wire wr_ready, // Receiver takes write word
    output wire [6:0] wr_addr, // Write register address
    output wire [15:0] wr_data, // Write data
    output wire busy // Activity indicator
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_DONE = 2'h2;

    wire sclk_s;
    wire din_s;
    wire cs_b_s;
    wire mode_s;
    reg [1:0] mode_wait_ff;
    reg sclk_d_ff;
    reg cs_d_ff;
    reg mode_ff;
    reg mode_cap_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [4:0] rise_cnt_ff;
    reg [4:0] fall_cnt_ff;
    reg [22:0] shift_ff;
    reg [15:0] out_sr_ff;
    reg rd_frame_ff;
    reg dout_ff;
    reg oe_ff;
    reg push_ff;
    reg [22:0] push_word_ff;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire push_ready;
    wire [22:0] buf_out;

    // Pins come from the master's domain, so each passes two flops
    sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
        .clock(clock),
        .rst_b(rst_b),
        .din(serial_clk),
        .dout(sclk_s)
    );
    sync2 #(.RST_VAL(1'b0)) u_sync_din (
        .clock(clock),
        .rst_b(rst_b),
        .din(serial_din),
        .dout(din_s)
    );
    sync2 #(.RST_VAL(1'b1)) u_sync_cs (
        .clock(clock),
        .rst_b(rst_b),
        .din(addr0_or_chip_select),
        .dout(cs_b_s)
    );
    // The strap is a pin as well, static or not
    sync2 #(.RST_VAL(1'b0)) u_sync_mode (
        .clock(clock),
        .rst_b(rst_b),
        .din(spi_mode_sel),
        .dout(mode_s)
    );

    // Strap caught once and held; the wait skips the sync's reset value
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= 1'b0;
            mode_cap_ff <= 1'b0;
            mode_wait_ff <= 2'h0;
        end else if (!mode_cap_ff) begin
            if (mode_wait_ff == `MODE_WAIT) begin
                mode_ff <= mode_s;
                mode_cap_ff <= 1'b1;
            end else begin
                mode_wait_ff <= mode_wait_ff + 2'h1;
            end
        end
    end

    // Edge detectors on synchronised copies
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_b_s;
        end
    end
    // Rising edge sampling works for either clock idle level
    // Five samples per half period at the top serial rate keep every edge visible
    assign sclk_rise = sclk_s && !sclk_d_ff;
    assign sclk_fall = !sclk_s && sclk_d_ff;
    assign cs_fall = !cs_b_s && cs_d_ff;
    assign cs_rise = cs_b_s && !cs_d_ff;

    // Frame state: counting is the same for bytes or a stream
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cs_fall && mode_ff && mode_cap_ff) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end else if (rise_cnt_ff == `FRAME_BITS && !rd_frame_ff) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Shift register and edge counters
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            rise_cnt_ff <= 5'h00;
            fall_cnt_ff <= 5'h00;
            shift_ff <= 23'h000000;
            rd_frame_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE) begin
                rise_cnt_ff <= 5'h00;
                fall_cnt_ff <= 5'h00;
                rd_frame_ff <= 1'b0;
            end else begin
                if (sclk_rise && rise_cnt_ff != `FRAME_BITS) begin
                    rise_cnt_ff <= rise_cnt_ff + 5'h01;
                    shift_ff <= {shift_ff[21:0], din_s};
                    if (rise_cnt_ff == 5'h00) begin
                        rd_frame_ff <= din_s;
                    end
                end
                if (sclk_fall && rise_cnt_ff != 5'h00) begin
                    fall_cnt_ff <= fall_cnt_ff + 5'h01;
                end
            end
        end
    end

    // Address decode once the command byte is in
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_addr <= 7'h00;
            rd_req <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            if (state_ff == ST_SHIFT && sclk_rise && rise_cnt_ff == `CMD_BITS - 5'h01) begin
                rd_addr <= {shift_ff[5:0], din_s};
                rd_req <= rd_frame_ff;
            end
        end
    end

    // Output shifter: the bit after the command goes out on the fall after the 8th rise
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_sr_ff <= 16'h0000;
            dout_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            if (rd_req) begin
                out_sr_ff <= rd_data | `ONES_MASK;
            end
            if (cs_b_s || state_ff == ST_IDLE || !mode_ff) begin
                oe_ff <= 1'b0;
            end else if (rd_frame_ff && sclk_fall && fall_cnt_ff >= `CMD_BITS - 5'h01
                         && fall_cnt_ff < `FRAME_BITS - 5'h01) begin
                dout_ff <= out_sr_ff[15];
                out_sr_ff <= {out_sr_ff[14:0], 1'b0};
                oe_ff <= 1'b1;
            end
        end
    end
    assign addr1_or_serial_out = dout_ff;
    assign addr1_or_serial_out_oe = oe_ff;

    // Write pushed only when complete frame closes with chip select rise
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            push_ff <= 1'b0;
            push_word_ff <= 23'h000000;
        end else begin
            if (push_ff && push_ready) begin
                push_ff <= 1'b0;
            end
            if (state_ff == ST_DONE && cs_rise) begin
                push_ff <= 1'b1;
                push_word_ff <= shift_ff;
            end
        end
    end

    // A stalled receiver backs up two words here and one in push_word_ff; a fourth write overwrites that one
    word_buf #(.WIDTH(23), .DEPTH(`BUF_DEPTH), .AW(1)) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(push_ff),
        .in_ready(push_ready),
        .in_data(push_word_ff),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out)
    );
    assign wr_addr = buf_out[22:16];
    assign wr_data = buf_out[15:0];

    // Busy during a frame or while writes are pending
    assign busy = (state_ff != ST_IDLE) || push_ff || wr_valid;
endmodule

// ### hw/spi_cmd_defines.vh
// Purpose: Shared constants for the four-wire serial command port.
// Assumes: Included by the port module only; the sync and buffer files do not use it.
// Notes: Frame is one command byte then sixteen data bits.
//
// Contract
// - Strap low picks two-wire port, high picks four-wire port; hold constant. No two-wire logic here: strap low leaves the port idle.
// - Each frame is exactly 24 bits: command byte then 16 data bits.
// - Input data is sampled on rising serial clock edges, either idle level.
// - A frame starts on the falling edge of chip select.
// - Read data is shifted out on falling serial clock edges.
// - Serial output floats whenever chip select is high.
// - A write executes only after 24 clocks and a chip select rise.
// - Chip select rising before the 23rd rising edge discards the command.
// - Early chip select rise during read floats output, resets port, loses data.
// - Device is slave only; master drives the serial clock.
// - In four-wire mode address pins act as chip select and output.
// - Activity output is high while the port is busy.
// - Serial clock rates up to 20 MHz are supported.
// - First four returned data bits of a read are ones.
// - Command top bit selects direction; zero means write.
`ifndef SPI_CMD_DEFINES_VH
`define SPI_CMD_DEFINES_VH

`define FRAME_BITS 5'h18
`define CMD_BITS 5'h08
`define ABORT_EDGE 5'h17
`define DIR_BIT 7
`define ONES_BITS 4
`define ONES_MASK 16'hF000
`define CLK_PERIOD_NS 5
`define SCLK_MAX_MHZ 20
`define SCLK_MIN_NS (1000 / `SCLK_MAX_MHZ)
`define SCLK_MIN_CYC ((`SCLK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUF_DEPTH 2
`define MODE_WAIT 2'h2

`endif

// ### hw/sync2.v
// Purpose: Two-stage synchroniser for one level from outside the clock domain.
// Assumes: Asynchronous active-low reset.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module sync2 #(
    parameter RST_VAL = 1'b0
) (
    input wire clock, // Block clock
    input wire rst_b, // Async reset, active low
    input wire din, // Asynchronous level
    output wire dout // Synchronised level
);
    reg meta_ff;
    reg sync_ff;

    // Two flops; the first is read by nothing else
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule

// ### hw/word_buf.v
// Purpose: Two-entry valid/ready buffer for completed write words.
// Assumes: Same clock on both sides.
// Notes: Depth is a power of two; data out comes from storage registers.
`timescale 1ns/1ps
module word_buf #(
    parameter WIDTH = 23,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire clock, // Block clock
    input wire rst_b, // Async reset, active low
    input wire in_valid, // Word offered
    output wire in_ready, // Space free
    input wire [WIDTH-1:0] in_data, // Offered word
    output wire out_valid, // Word held
    input wire out_ready, // Receiver takes word
    output wire [WIDTH-1:0] out_data // Oldest word
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0] cnt_ff;
    wire push;
    wire pop;

    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ff];

    // Storage has no reset; occupancy guards it
    always @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

// ### testbench/spi_cmd_port_properties.sv
// Purpose: Pin timing checks for the serial command port.
// Assumes: Sees only the port's own signals.
// Notes: Windows allow for the two-flop sync latency.
`timescale 1ns/1ps
module spi_cmd_port_properties (
    input wire clock, // Block clock
    input wire rst_b, // Async reset, active low
    input wire spi_mode_sel, // Strap
    input wire serial_clk, // Serial clock
    input wire serial_din, // Serial data in
    input wire addr0_or_chip_select, // Chip select, active low
    input wire addr2_or_unused, // Unused pin
    input wire addr1_or_serial_out, // Serial out
    input wire addr1_or_serial_out_oe, // Out enable
    input wire [6:0] rd_addr, // Read address
    input wire rd_req, // Read pulse
    input wire [15:0] rd_data, // Read data
    input wire wr_valid, // Word held
    input wire wr_ready, // Word taken
    input wire [6:0] wr_addr, // Write address
    input wire [15:0] wr_data, // Write data
    input wire busy // Activity
);
    wire cs = addr0_or_chip_select;
    wire oe = addr1_or_serial_out_oe;
    wire so = addr1_or_serial_out;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_float; cs [*5] |-> !oe; endproperty
    a_float: assert property (p_float) else $error("out driven while off");
    property p_strap; !spi_mode_sel |-> !oe && !rd_req; endproperty
    a_strap: assert property (p_strap) else $error("port live with strap low");
    property p_start; $rose(oe) |-> !cs; endproperty
    a_start: assert property (p_start) else $error("drive outside frame");
    property p_rdreq; rd_req |-> !cs ##1 !rd_req; endproperty
    a_rdreq: assert property (p_rdreq) else $error("read pulse bad");
    // Output moves only while serial clock is low after a fall
    property p_shift; oe && $past(oe) && so != $past(so) |-> !serial_clk; endproperty
    a_shift: assert property (p_shift) else $error("out moved on rise");
    property p_push; $rose(wr_valid) |-> cs && $past(cs); endproperty
    a_push: assert property (p_push) else $error("write before deselect");
    property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}); endproperty
    a_hold: assert property (p_hold) else $error("stalled word lost");
    property p_busy_frame; (spi_mode_sel && !cs) [*5] |-> busy; endproperty
    a_busy_frame: assert property (p_busy_frame) else $error("idle in frame");
    property p_busy_wr; wr_valid |-> busy; endproperty
    a_busy_wr: assert property (p_busy_wr) else $error("idle with word");
    c_read: cover property (rd_req);
    c_pop: cover property (wr_valid && wr_ready);
    c_float: cover property ($fell(oe));
endmodule
bind spi_cmd_port spi_cmd_port_properties spi_cmd_port_properties_inst (.*);

// ### testbench/spi_master_model.sv
// Purpose: Serial master that sends frames and collects read bits.
// Assumes: Half period 62.5 ns; clock stands still between frames.
// Notes: Sampling returned bits on rises leaves a half period of setup.
`timescale 1ns/1ps
module spi_master_model (
    output reg sclk, // Serial clock
    output reg mosi, // Data to slave
    output reg cs_b, // Chip select, active low
    input wire miso, // Data from slave
    input wire miso_oe // Slave drive enable
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        cs_b = 1'b1;
    end
    // Send n bits MSB first; gap splits the frame into bytes
    task frame(input [23:0] tx, input integer n, input idle, input gap, output [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            sclk = idle;
            #100 cs_b = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                if (gap && i > 0 && i % 8 == 0) #400;
                #62.5 sclk = 1'b0;
                mosi = tx[23 - i];
                #62.5 sclk = 1'b1;
                if (i > 7) rx[23 - i] = miso_oe ? miso : 1'bz;
            end
            // Released data line must not keep its last value
            #62.5 mosi = ~mosi;
            sclk = idle;
            #62.5 cs_b = 1'b1;
        end
    endtask
endmodule

// ### testbench/spi_cmd_port_tb.sv
// Purpose: Self-checking bench for the serial command port.
// Assumes: Master model drives the pins; bench is register side.
// Notes: Read data is an address pattern known to the bench.
`timescale 1ns/1ps
module spi_cmd_port_tb;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg strap = 1'b1;
    reg wr_ready = 1'b0;
    wire sclk, mosi, cs_b, so, oe, rd_req, wr_valid, busy;
    wire [6:0] rd_addr, wr_addr;
    wire [15:0] wr_data, rd_data;
    reg [15:0] rx;
    integer bad_count = 0;
    integer comparisons = 0;
    integer k;
    always #2.5 clock = ~clock;
    // Register file stand-in
    assign rd_data = {9'h0B4, rd_addr};
    spi_cmd_port spi_cmd_port_inst (.clock(clock), .rst_b(rst_b), .spi_mode_sel(strap),
        .serial_clk(sclk), .serial_din(mosi), .addr0_or_chip_select(cs_b),
        .addr2_or_unused(1'b0), .addr1_or_serial_out(so), .addr1_or_serial_out_oe(oe),
        .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
    spi_master_model spi_master_model_inst (.sclk(sclk), .mosi(mosi), .cs_b(cs_b),
        .miso(so), .miso_oe(oe));
    task check(input [8*10-1:0] what, input [23:0] seen, input [23:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Wait for a word, compare it, pop it
    task pop(input [6:0] a, input [15:0] d);
        begin
            @(posedge clock) #1;
            for (k = 0; k < 100 && wr_valid !== 1'b1; k = k + 1) @(posedge clock) #1;
            check("wr_addr", wr_addr, a);
            check("wr_data", wr_data, d);
            wr_ready = 1'b1;
            @(posedge clock) #1 wr_ready = 1'b0;
        end
    endtask
    task t_write;
        begin
            spi_master_model_inst.frame(24'h15A53C, 24, 1'b0, 1'b0, rx);
            pop(7'h15, 16'hA53C);
            $display("write test done");
        end
    endtask
    // Reads at both idle levels: four ones, then data
    task t_read;
        begin
            spi_master_model_inst.frame(24'hAA0000, 24, 1'b1, 1'b0, rx);
            check("rd_high", rx, {4'hF, 5'h14, 7'h2A});
            spi_master_model_inst.frame(24'h81FFFF, 24, 1'b0, 1'b0, rx);
            check("rd_low", rx, {4'hF, 5'h14, 7'h01});
            repeat (6) @(posedge clock) #1;
            check("float", oe, 1'b0);
            check("no_push", wr_valid, 1'b0);
            $display("read test done");
        end
    endtask
    // Receiver stalled over two byte-wise writes
    task t_buffer;
        begin
            spi_master_model_inst.frame(24'h7F8001, 24, 1'b1, 1'b1, rx);
            spi_master_model_inst.frame(24'h001234, 24, 1'b0, 1'b1, rx);
            check("busy", busy, 1'b1);
            pop(7'h7F, 16'h8001);
            pop(7'h00, 16'h1234);
            check("empty", wr_valid, 1'b0);
            check("idle", busy, 1'b0);
            $display("buffer test done");
        end
    endtask
    // Write cut after 22 rises, read cut after 12
    task t_abort;
        begin
            spi_master_model_inst.frame(24'h05FFFF, 22, 1'b0, 1'b0, rx);
            repeat (20) @(posedge clock) #1;
            check("abort", wr_valid, 1'b0);
            spi_master_model_inst.frame(24'h850000, 12, 1'b1, 1'b0, rx);
            repeat (6) @(posedge clock) #1;
            check("cut_float", oe, 1'b0);
            spi_master_model_inst.frame(24'h065AA5, 24, 1'b0, 1'b0, rx);
            pop(7'h06, 16'h5AA5);
            $display("abort test done");
        end
    endtask
    // Strap low at reset leaves the port deaf
    task t_strap;
        begin
            @(posedge clock) #1 rst_b = 1'b0;
            strap = 1'b0;
            repeat (5) @(posedge clock) #1;
            rst_b = 1'b1;
            spi_master_model_inst.frame(24'h810000, 24, 1'b0, 1'b0, rx);
            check("strap", rx, 16'hZZZZ);
            check("strap_busy", busy, 1'b0);
            $display("strap test done");
        end
    endtask
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clock);
        t_write;
        t_read;
        t_buffer;
        t_abort;
        t_strap;
        print_verdict;
    end
    // Watchdog far past the nine frames of the run
    initial begin
        #200000;
        bad_count = bad_count + 1;
        print_verdict;
    end
endmodule
